//--- rtl/ismg_pkg.sv
// constants, register map and state codes for the idle/slow-down/module-gating block
package ismg_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0]  OFF_CLOCK_DIVIDER      = 8'h00;
   localparam logic [7:0]  OFF_PERIPHERAL_DISABLE = 8'h04;
   localparam logic [7:0]  OFF_STATUS             = 8'h08;

   // ****************************************
   // field positions
   // ****************************************
   localparam int          POS_RETURN_ON_INT      = 15;
   localparam int          POS_RATIO_HI           = 14;
   localparam int          POS_RATIO_LO           = 12;
   localparam int          POS_SLOWDOWN_EN        = 11;
   localparam int          POS_UART4_OFF          = 5;
   localparam int          POS_REFCLK_OFF         = 3;
   localparam int          POS_USB_OFF            = 0;
   localparam int          POS_ST_IDLE            = 0;
   localparam int          POS_ST_SLOW            = 1;
   localparam int          POS_ST_MOD_LO          = 4;

   // ****************************************
   // sizes and reset values
   // ****************************************
   localparam int          REG_W                  = 16;
   localparam int          RATIO_W                = 3;
   localparam int          DIV_W                  = 7;
   localparam int          NUM_MODULES            = 3;
   localparam int          MOD_USB                = 0;
   localparam int          MOD_REFCLK             = 1;
   localparam int          MOD_UART4              = 2;
   localparam logic [15:0] RST_CLOCK_DIVIDER      = 16'h0000;
   localparam logic [15:0] RST_PERIPHERAL_DISABLE = 16'h0000;
   localparam logic [RATIO_W-1:0] RATIO_ONE_TO_ONE = 3'h0;

   // ****************************************
   // timing
   // ****************************************
   localparam int          CLK_PERIOD_NS          = 20;
   localparam int          WAKE_MIN_CYCLES        = 2;
   localparam int          WAKE_MAX_CYCLES        = 4;
   // wake_cnt value that ends ST_WAKE: three held clock cycles between the wake event and the clock returning
   localparam logic [2:0]  WAKE_LAST              = 3'h2;
   // one instruction cycle equals one clock of this domain
   localparam int          INSTR_CYCLE_NS         = 20;
   localparam int          MOD_DELAY_CYCLES       = INSTR_CYCLE_NS / CLK_PERIOD_NS;

   // ****************************************
   // power-save sequencer states
   // ****************************************
   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_ENTER = 4'b0010,
      ST_IDLE  = 4'b0100,
      ST_WAKE  = 4'b1000
   } ismg_state_t;

endpackage

//--- rtl/ismg_clk_gate.sv
// glitch-free clock gate whose enable changes only while the clock is low
`timescale 1ns/1ns
module ismg_clk_gate #(
   parameter bit RESET_ON = 1'b1
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rstn_in,
   // control
   input  wire logic en_in,
   // gated clock
   output logic      gclk_out
);

   logic en_low;

   // enable is taken on the falling edge, so the and-gate never cuts a high phase
   always_ff @(negedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en_low <= RESET_ON;
      end else begin
         en_low <= en_in;
      end
   end

   assign gclk_out = clk_in & en_low;

endmodule // ismg_clk_gate

//--- rtl/ismg_ctrl.sv
// idle mode, cpu slow-down and per-module clock gating controller with apb registers
`timescale 1ns/1ns
module ismg_ctrl
   import ismg_pkg::*;
#(
   parameter int N_MOD = NUM_MODULES
) (
   // clock, reset, clock enable
   input  wire logic             ref_clk_in,
   input  wire logic             rstn_in,
   input  wire logic             clk_en_in,
   // apb slave
   input  wire logic             psel_in,
   input  wire logic             penable_in,
   input  wire logic             pwrite_in,
   input  wire logic [7:0]       paddr_in,
   input  wire logic [31:0]      pwdata_in,
   output logic                  pready_out,
   output logic                  pslverr_out,
   output logic [31:0]           prdata_out,
   // cpu side events
   input  wire logic             power_save_instruction_in,
   input  wire logic             irq_pending_in,
   input  wire logic             watchdog_timeout_in,
   input  wire logic             watchdog_enable_in,
   input  wire logic             fail_safe_clock_monitor_enable_in,
   // variant straps: which modules exist
   input  wire logic [N_MOD-1:0] module_present_in,
   // clocks out
   output logic                  cpu_clk_out,
   output logic                  periph_clk_out,
   output logic [N_MOD-1:0]      module_clk_out,
   // status to cpu, watchdog, oscillator and modules
   output logic                  cpu_halted_out,
   output logic                  watchdog_clear_out,
   output logic                  low_power_rc_oscillator_enable_out,
   output logic [N_MOD-1:0]      module_reg_enable_out
);

   // ****************************************
   // functions
   // ****************************************
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
      addr_hit = (addr == off);
   endfunction

   // all-ones in the low `code` bits: ratio 1:2^code
   function automatic logic [DIV_W-1:0] ratio_mask(input logic [RATIO_W-1:0] code);
      logic [DIV_W:0] one_hot;
      one_hot    = '0;
      one_hot    = (DIV_W+1)'(1) << code;
      ratio_mask = DIV_W'(one_hot - (DIV_W+1)'(1));
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   ismg_state_t        state;
   ismg_state_t        next_state;
   logic [2:0]         wake_cnt;
   logic [REG_W-1:0]   clock_divider_register;
   logic [REG_W-1:0]   peripheral_disable_4;
   logic [N_MOD-1:0]   module_on;
   logic [DIV_W-1:0]   div_cnt;
   logic [31:0]        rd_word;

   wire  logic [N_MOD-1:0]   module_clock_disable;
   wire  logic               return_on_interrupt;
   wire  logic               cpu_slowdown_enable;
   wire  logic [RATIO_W-1:0] ratio;
   wire  logic               hit_div;
   wire  logic               hit_pmd;
   wire  logic               hit_stat;
   wire  logic               unmapped;
   wire  logic               apb_setup;
   wire  logic               apb_access;
   wire  logic               wr_div;
   wire  logic               wr_pmd;
   wire  logic               wake_evt;
   wire  logic               roi_hit;
   wire  logic               cpu_tick;
   wire  logic               cpu_run;
   wire  logic               cpu_gate_en;
   wire  logic [N_MOD-1:0]   next_module_on;
   wire  logic [REG_W-1:0]   status_word;

   // ****************************************
   // apb decode
   // ****************************************
   assign hit_div    = addr_hit(paddr_in, OFF_CLOCK_DIVIDER);
   assign hit_pmd    = addr_hit(paddr_in, OFF_PERIPHERAL_DISABLE);
   assign hit_stat   = addr_hit(paddr_in, OFF_STATUS);
   assign unmapped   = !(hit_div || hit_pmd || hit_stat);
   assign apb_setup  = psel_in && !penable_in;
   assign apb_access = psel_in && penable_in;
   assign wr_div     = apb_access && pwrite_in && hit_div;
   assign wr_pmd     = apb_access && pwrite_in && hit_pmd;

   // zero wait states: every access phase completes at once
   assign pready_out  = apb_access;
   assign pslverr_out = apb_access && unmapped;

   // ****************************************
   // register fields
   // ****************************************
   assign return_on_interrupt = clock_divider_register[POS_RETURN_ON_INT];
   assign cpu_slowdown_enable = clock_divider_register[POS_SLOWDOWN_EN];
   assign ratio               = clock_divider_register[POS_RATIO_HI:POS_RATIO_LO];

   assign module_clock_disable[MOD_USB]    = peripheral_disable_4[POS_USB_OFF];
   assign module_clock_disable[MOD_REFCLK] = peripheral_disable_4[POS_REFCLK_OFF];
   assign module_clock_disable[MOD_UART4]  = peripheral_disable_4[POS_UART4_OFF];

   assign roi_hit = irq_pending_in && return_on_interrupt && cpu_slowdown_enable;

   // only the implemented bits take writes; the rest stay zero
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         clock_divider_register <= RST_CLOCK_DIVIDER;
      end else if (clk_en_in) begin
         if (wr_div) begin
            clock_divider_register[POS_RETURN_ON_INT]         <= pwdata_in[POS_RETURN_ON_INT];
            clock_divider_register[POS_RATIO_HI:POS_RATIO_LO] <= pwdata_in[POS_RATIO_HI:POS_RATIO_LO];
            clock_divider_register[POS_SLOWDOWN_EN]           <= pwdata_in[POS_SLOWDOWN_EN];
         end
         // interrupt return to full speed beats a simultaneous write of the enable
         if (roi_hit) begin
            clock_divider_register[POS_SLOWDOWN_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         peripheral_disable_4 <= RST_PERIPHERAL_DISABLE;
      end else if (clk_en_in && wr_pmd) begin
         peripheral_disable_4[POS_UART4_OFF]  <= pwdata_in[POS_UART4_OFF];
         peripheral_disable_4[POS_REFCLK_OFF] <= pwdata_in[POS_REFCLK_OFF];
         peripheral_disable_4[POS_USB_OFF]    <= pwdata_in[POS_USB_OFF];
      end
   end

   // ****************************************
   // module enables, one instruction cycle behind the disable bits
   // ****************************************
   assign next_module_on = module_present_in & ~module_clock_disable;

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         module_on <= '1;
      end else if (clk_en_in) begin
         module_on <= next_module_on;
      end
   end

   // blocked modules ignore writes; their read data must not be trusted
   assign module_reg_enable_out = module_on;

   // ****************************************
   // readback
   // ****************************************
   assign status_word = REG_W'({module_on, {(POS_ST_MOD_LO-POS_ST_SLOW-1){1'b0}},
                                cpu_slowdown_enable, cpu_halted_out});

   always_comb begin
      rd_word = '0;
      if (hit_div) begin
         rd_word[REG_W-1:0] = clock_divider_register;
      end else if (hit_pmd) begin
         rd_word[REG_W-1:0] = peripheral_disable_4;
      end else if (hit_stat) begin
         rd_word[REG_W-1:0] = status_word;
      end
   end

   // read data is caught in the setup cycle and stands through the access
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_out <= '0;
      end else if (clk_en_in && apb_setup) begin
         prdata_out <= pwrite_in ? 32'h0000_0000 : rd_word;
      end
   end

   // ****************************************
   // idle sequencer
   // ****************************************
   // a device reset wakes through rstn_in itself
   assign wake_evt = irq_pending_in || watchdog_timeout_in;

   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (power_save_instruction_in) begin
               next_state = ST_ENTER;
            end
         end
         ST_ENTER: begin
            // interrupts are not looked at here; a held request wakes from idle next
            next_state = ST_IDLE;
         end
         ST_IDLE: begin
            if (wake_evt) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wake_cnt == WAKE_LAST) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state    <= ST_RUN;
         wake_cnt <= '0;
      end else if (clk_en_in) begin
         state    <= next_state;
         wake_cnt <= (state == ST_WAKE) ? wake_cnt + 3'h1 : 3'h0;
      end
   end

   assign cpu_halted_out     = (state == ST_ENTER) || (state == ST_IDLE);
   assign watchdog_clear_out = (state == ST_ENTER);

   // oscillator request ignores the idle state on purpose
   assign low_power_rc_oscillator_enable_out =
      watchdog_enable_in || fail_safe_clock_monitor_enable_in;

   // ****************************************
   // cpu slow-down divider
   // ****************************************
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_cnt <= '0;
      end else if (clk_en_in) begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   // with slow-down on, the cpu gets every 2^ratio-th edge of the same clock, so both stay in step
   assign cpu_tick = !cpu_slowdown_enable || ((div_cnt & ratio_mask(ratio)) == '0);
   assign cpu_run  = (state == ST_RUN);
   assign cpu_gate_en = clk_en_in && cpu_run && cpu_tick;

   // ****************************************
   // clock gates
   // ****************************************
   ismg_clk_gate #(
      .RESET_ON (1'b1)
   ) u_cpu_gate (
      .clk_in   (ref_clk_in),
      .rstn_in  (rstn_in),
      .en_in    (cpu_gate_en),
      .gclk_out (cpu_clk_out)
   );

   // module clock never sees the divider or the idle state
   ismg_clk_gate #(
      .RESET_ON (1'b1)
   ) u_periph_gate (
      .clk_in   (ref_clk_in),
      .rstn_in  (rstn_in),
      .en_in    (clk_en_in),
      .gclk_out (periph_clk_out)
   );

   generate
      for (genvar m = 0; m < N_MOD; m++) begin : g_mod
         ismg_clk_gate #(
            .RESET_ON (1'b1)
         ) u_mod_gate (
            .clk_in   (ref_clk_in),
            .rstn_in  (rstn_in),
            .en_in    (clk_en_in && module_on[m]),
            .gclk_out (module_clk_out[m])
         );
      end
   endgenerate

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rstn_in);

   idle_halt_a: assert property (
      cpu_halted_out |-> !cpu_gate_en
   ) else $error("cpu clock enabled while idle");

   wdt_clear_a: assert property (
      (state == ST_RUN && power_save_instruction_in && clk_en_in) |=> watchdog_clear_out ##1 !watchdog_clear_out
   ) else $error("watchdog clear pulse missing on idle entry");

   low_power_rc_oscillator_idle_a: assert property (
      (cpu_halted_out && watchdog_enable_in) |-> low_power_rc_oscillator_enable_out
   ) else $error("rc oscillator off in idle with watchdog on");

   idle_wake_a: assert property (
      (state == ST_IDLE && wake_evt && clk_en_in) |=> (state == ST_WAKE)
   ) else $error("idle did not end on wake event");

   wake_time_a: assert property (
      (state == ST_IDLE && wake_evt && clk_en_in) ##1 clk_en_in [*4] |-> (state == ST_RUN)
   ) else $error("cpu not restored four cycles after wake");

   defer_irq_a: assert property (
      (state == ST_ENTER && clk_en_in) |=> (state == ST_IDLE)
   ) else $error("interrupt not deferred during idle entry");

   slow_off_a: assert property (
      (!cpu_slowdown_enable && cpu_run && clk_en_in) |-> cpu_gate_en
   ) else $error("cpu clock divided with slow-down off");

   roi_return_a: assert property (
      (roi_hit && clk_en_in) |=> !cpu_slowdown_enable
   ) else $error("interrupt did not restore full speed");

   ratio_two_a: assert property (
      (cpu_slowdown_enable && ratio == 3'h1 && cpu_tick && clk_en_in && !wr_div && !roi_hit) |=> !cpu_tick
   ) else $error("ratio 1:2 gave two ticks in a row");

   pmd_delay_a: assert property (
      (wr_pmd && clk_en_in && module_present_in[MOD_USB]) ##1 clk_en_in
         |=> (module_on[MOD_USB] == !$past(pwdata_in[POS_USB_OFF], 2))
   ) else $error("usb enable not updated one cycle after write");

endmodule // ismg_ctrl

//--- bench/ismg_core_model.sv
// behavioural cpu core and modules that count the edges of the clocks they receive
`timescale 1ns/1ns
module ismg_core_model
   import ismg_pkg::*;
(
   // reset and gated clocks from the controller
   input  wire logic                    rstn_in,
   input  wire logic                    cpu_clk_in,
   input  wire logic                    periph_clk_in,
   input  wire logic [NUM_MODULES-1:0]  module_clk_in,
   // edges seen so far
   output logic [31:0]                  cpu_edges_out,
   output logic [31:0]                  periph_edges_out,
   output logic [NUM_MODULES-1:0][31:0] module_edges_out
);
   // ****************************************
   // edge counters
   // ****************************************
   // a runt pulse still counts, so a gating glitch shows up as a surplus edge
   always_ff @(posedge cpu_clk_in or negedge rstn_in) begin
      if (!rstn_in) cpu_edges_out <= '0;
      else cpu_edges_out <= cpu_edges_out + 32'h1;
   end
   always_ff @(posedge periph_clk_in or negedge rstn_in) begin
      if (!rstn_in) periph_edges_out <= '0;
      else periph_edges_out <= periph_edges_out + 32'h1;
   end
   for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
      always_ff @(posedge module_clk_in[g] or negedge rstn_in) begin
         if (!rstn_in) module_edges_out[g] <= '0;
         else module_edges_out[g] <= module_edges_out[g] + 32'h1;
      end
   end
endmodule // ismg_core_model

//--- bench/testbench.sv
// self-checking bench for the idle, slow-down and module clock gating controller
`timescale 1ns/1ns
module testbench;
   import ismg_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic                    ref_clk_in, rstn_in, clk_en_in;
   logic                    psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [7:0]              paddr_in;
   logic [31:0]             pwdata_in, prdata_out, rd, er, d;
   logic                    power_save_instruction_in, irq_pending_in, watchdog_timeout_in;
   logic                    watchdog_enable_in, fail_safe_clock_monitor_enable_in;
   logic [2:0]              module_present_in, module_clk_out, module_reg_enable_out, prev;
   logic                    cpu_clk_out, periph_clk_out, cpu_halted_out, watchdog_clear_out;
   logic                    low_power_rc_oscillator_enable_out;
   logic [31:0]             cpu_cnt, per_cnt;
   logic [2:0][31:0]        mod_cnt;
   int                      mismatches, n_checks, seed, i, s, n, k, dc, dp, c0;
   int                      dm [3];

   ismg_ctrl #(.N_MOD(NUM_MODULES)) ismg_ctrl_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .clk_en_in(clk_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .prdata_out(prdata_out), .power_save_instruction_in(power_save_instruction_in),
      .irq_pending_in(irq_pending_in), .watchdog_timeout_in(watchdog_timeout_in),
      .watchdog_enable_in(watchdog_enable_in),
      .fail_safe_clock_monitor_enable_in(fail_safe_clock_monitor_enable_in),
      .module_present_in(module_present_in), .cpu_clk_out(cpu_clk_out), .periph_clk_out(periph_clk_out),
      .module_clk_out(module_clk_out), .cpu_halted_out(cpu_halted_out),
      .watchdog_clear_out(watchdog_clear_out),
      .low_power_rc_oscillator_enable_out(low_power_rc_oscillator_enable_out),
      .module_reg_enable_out(module_reg_enable_out));
   ismg_core_model ismg_core_model_i (.rstn_in(rstn_in), .cpu_clk_in(cpu_clk_out),
      .periph_clk_in(periph_clk_out), .module_clk_in(module_clk_out), .cpu_edges_out(cpu_cnt),
      .periph_edges_out(per_cnt), .module_edges_out(mod_cnt));

   // ****************************************
   // tasks and expectations
   // ****************************************
   function automatic logic [2:0] exp_on(input logic [31:0] dis, input logic [2:0] pres);
      return {~dis[5], ~dis[3], ~dis[0]} & pres;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge ref_clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= wd;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      // no local limit: a slave that never answers is caught by the watchdog
      do begin
         @(posedge ref_clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      er = {31'h0, pslverr_out};
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // edge counts over n whole clock periods, taken between falling edges
   task win(input int nc);
      int p0;
      int m0 [3];
      @(negedge ref_clk_in);
      c0 = cpu_cnt;
      p0 = per_cnt;
      for (int g = 0; g < 3; g++) m0[g] = mod_cnt[g];
      repeat (nc) @(negedge ref_clk_in);
      dc = cpu_cnt - c0;
      dp = per_cnt - p0;
      for (int g = 0; g < 3; g++) dm[g] = mod_cnt[g] - m0[g];
   endtask
   task close_out;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ****************************************
   // clock, watchdog and scenarios
   // ****************************************
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      repeat (12000) @(posedge ref_clk_in);
      mismatches++;
      close_out;
   end
   initial begin
      seed = 28641;
      rstn_in = 1'b0; clk_en_in = 1'b1; psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0;
      paddr_in = 8'h00; pwdata_in = 32'h0; power_save_instruction_in = 1'b0; irq_pending_in = 1'b0;
      watchdog_timeout_in = 1'b0; watchdog_enable_in = 1'b0; fail_safe_clock_monitor_enable_in = 1'b0;
      module_present_in = 3'h7;
      repeat (2) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      apb(OFF_CLOCK_DIVIDER, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(OFF_PERIPHERAL_DISABLE, 1'b0, 32'h0);
      chk(rd, 32'h0);
      #1;
      chk(module_reg_enable_out, 32'h7);
      apb(8'h40, 1'b0, 32'h0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      // corner values first, then random disable patterns
      prev = 3'h7;
      for (i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : (i == 2) ? 32'h21 : $random(seed);
         if (i == 9) d = 32'h0;
         apb(OFF_PERIPHERAL_DISABLE, 1'b1, d);
         #1;
         chk(module_reg_enable_out, prev);
         @(posedge ref_clk_in);
         #1;
         chk(module_reg_enable_out, exp_on(d, 3'h7));
         apb(OFF_PERIPHERAL_DISABLE, 1'b0, 32'h0);
         chk(rd, d & 32'h29);
         apb(OFF_STATUS, 1'b0, 32'h0);
         chk(rd, {25'h0, exp_on(d, 3'h7), 4'h0});
         win(16);
         for (int g = 0; g < 3; g++) chk(dm[g], exp_on(d, 3'h7) >> g & 1 ? 16 : 0);
         prev = exp_on(d, 3'h7);
      end
      @(posedge ref_clk_in);
      module_present_in <= 3'h3;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk(module_reg_enable_out, 32'h3);
      win(16);
      chk(dm[2], 0);
      @(posedge ref_clk_in);
      module_present_in <= 3'h7;
      // idle entry, then wake by interrupt, by watchdog time-out, and by an early interrupt
      for (s = 0; s < 3; s++) begin
         @(posedge ref_clk_in);
         power_save_instruction_in <= 1'b1;
         irq_pending_in            <= (s == 2);
         @(posedge ref_clk_in);
         power_save_instruction_in <= 1'b0;
         #1;
         chk(watchdog_clear_out, 1);
         chk(cpu_halted_out, 1);
         @(posedge ref_clk_in);
         #1;
         chk(watchdog_clear_out, 0);
         if (s != 2) begin
            win(12);
            chk(dc, 0);
            chk(dp, 12);
            chk(dm[2], 12);
         end
         if (s == 0) for (i = 0; i < 4; i++) begin
            @(posedge ref_clk_in);
            watchdog_enable_in                <= i[0];
            fail_safe_clock_monitor_enable_in <= i[1];
            @(posedge ref_clk_in);
            #1;
            chk(low_power_rc_oscillator_enable_out, i[0] | i[1]);
         end
         @(posedge ref_clk_in);
         irq_pending_in      <= (s != 1);
         watchdog_timeout_in <= (s == 1);
         c0 = cpu_cnt;
         n = 0;
         do begin
            @(posedge ref_clk_in);
            #1;
            n++;
         end while (cpu_cnt == c0 && n < 12);
         chk(cpu_halted_out, 0);
         k = n - (s != 2);
         chk(k >= 2 && k <= 4, 1);
         @(posedge ref_clk_in);
         irq_pending_in      <= 1'b0;
         watchdog_timeout_in <= 1'b0;
      end
      // every ratio code, then slow-down switched off with a ratio still set
      for (i = 0; i < 9; i++) begin
         apb(OFF_CLOCK_DIVIDER, 1'b1, (i < 8) ? 32'h800 | (i << 12) : 32'h7000);
         win(256);
         chk(dc, (i < 8) ? 256 >> i : 256);
         chk(dp, 256);
         chk(dm[1], 256);
      end
      // clock enable low must freeze every gated clock
      @(posedge ref_clk_in);
      clk_en_in <= 1'b0;
      win(8);
      chk(dc, 0);
      chk(dp, 0);
      chk(dm[0], 0);
      @(posedge ref_clk_in);
      clk_en_in <= 1'b1;
      for (i = 0; i < 2; i++) begin
         apb(OFF_CLOCK_DIVIDER, 1'b1, (i << 15) | 32'h3800);
         irq_pending_in <= 1'b1;
         @(posedge ref_clk_in);
         irq_pending_in <= 1'b0;
         apb(OFF_CLOCK_DIVIDER, 1'b0, 32'h0);
         chk(rd, i ? 32'hb000 : 32'h3800);
         win(64);
         chk(dc, i ? 64 : 8);
      end
      close_out;
   end
endmodule // testbench
